//--- design/tci_consts.vh
/*
 * Constants of the timekeeper interrupt block: register indices, field
 * positions, reset values and synchroniser depth.
 * Assumes byte addresses on the APB are four times the register index.
 */
`ifndef TCI_CONSTS_VH
`define TCI_CONSTS_VH

// ******************************************************************
// Register map
// ******************************************************************
`define TCI_IEN_IDX     16'h56C2
`define TCI_IFLG_IDX    16'h56C4
`define TCI_CAUSES      10
`define TCI_REG_W       16
`define TCI_IEN_RST     10'h000
`define TCI_IFLG_RST    10'h000

// ******************************************************************
// Field positions
// ******************************************************************
`define TCI_BIT_T32     0
`define TCI_BIT_T8      1
`define TCI_BIT_T4      2
`define TCI_BIT_T1      3
`define TCI_BIT_TENSEC  4
`define TCI_BIT_MINUTE  5
`define TCI_BIT_TENMIN  6
`define TCI_BIT_HOUR    7
`define TCI_BIT_HALFDAY 8
`define TCI_BIT_DAY     9

// ******************************************************************
// Timing
// ******************************************************************
`define TCI_SYNC_STAGES 2

`endif

//--- design/tci_roll_detect.v
/*
 * Counter rollover detector: compares the calendar counters with their
 * previous values and pulses one cycle per documented transition.
 * Assumes the counters and mode bits are driven on CORE_CLK.
 */
`timescale 1ns/1ps
`include "tci_consts.vh"

module tci_roll_detect (
  input  wire       clk,
  input  wire       srst,
  input  wire [6:0] sec_count,
  input  wire [6:0] min_count,
  input  wire [5:0] hour_count,
  input  wire       hour_pm,
  input  wire       mode_12h,
  input  wire       mode_bcd,
  output wire [5:0] roll
);

  reg  [6:0] prev_sec;
  reg  [6:0] prev_min;
  reg  [5:0] prev_hour;
  reg        prev_pm;
  reg        primed;
  wire [6:0] s_now;
  wire [6:0] s_old;
  wire [6:0] m_now;
  wire [6:0] m_old;
  wire [6:0] h_now;
  wire [6:0] h_old;
  wire       sec_wrap;
  wire       min_wrap;
  wire       noon;
  wire       midnight;

  // Decimal value of a counter field in either coding
  function [6:0] to_dec;
    input [6:0] v;
    input       bcd;
    begin
      if (bcd) begin
        to_dec = (v[6:4] * 7'd10) + {3'b000, v[3:0]};
      end else begin
        to_dec = v;
      end
    end
  endfunction

  // Step out of 9, 19, 29, 39 or 49 into the next ten
  function tens_step;
    input [6:0] old_v;
    input [6:0] new_v;
    begin
      tens_step = ((old_v == 7'd9) || (old_v == 7'd19) || (old_v == 7'd29) ||
                   (old_v == 7'd39) || (old_v == 7'd49)) && (new_v == old_v + 7'd1);
    end
  endfunction

  assign s_now = to_dec(sec_count, mode_bcd);
  assign s_old = to_dec(prev_sec, mode_bcd);
  assign m_now = to_dec(min_count, mode_bcd);
  assign m_old = to_dec(prev_min, mode_bcd);
  assign h_now = to_dec({1'b0, hour_count}, mode_bcd);
  assign h_old = to_dec({1'b0, prev_hour}, mode_bcd);

  assign sec_wrap = primed && (s_old == 7'd59) && (s_now == 7'd0);
  assign min_wrap = primed && (m_old == 7'd59) && (m_now == 7'd0);
  assign noon     = primed && (h_old == 7'd11) && (h_now == 7'd12) &&
                    (!mode_12h || (!prev_pm && hour_pm));
  assign midnight = primed && (mode_12h ?
                    ((h_old == 7'd11) && (h_now == 7'd12) && prev_pm && !hour_pm) :
                    ((h_old == 7'd23) && (h_now == 7'd0)));

  assign roll[0] = sec_wrap || (primed && tens_step(s_old, s_now));
  assign roll[1] = sec_wrap;
  assign roll[2] = min_wrap || (primed && tens_step(m_old, m_now));
  assign roll[3] = min_wrap;
  assign roll[4] = noon || midnight;
  assign roll[5] = midnight;

  // Primed stops a spurious event on the first compare after reset
  always @(posedge clk) begin
    if (srst) begin
      prev_sec  <= 7'h00;
      prev_min  <= 7'h00;
      prev_hour <= 6'h00;
      prev_pm   <= 1'b0;
      primed    <= 1'b0;
    end else begin
      prev_sec  <= sec_count;
      prev_min  <= min_count;
      prev_hour <= hour_count;
      prev_pm   <= hour_pm;
      primed    <= 1'b1;
    end
  end

endmodule // tci_roll_detect

//--- design/tci_irq.v
/*
 * Timekeeper interrupt block: enable and flag registers on APB, divider
 * tick capture, rollover capture and the request to the interrupt
 * controller.
 * Assumes divider ticks are square waves from the oscillator domain, the
 * counters run on CORE_CLK, and CORE_CLK keeps running in sleep.
 */
`timescale 1ns/1ps
`include "tci_consts.vh"

module tci_irq #(
  parameter ADDR_W = 18
) (
  input  wire              CORE_CLK,
  input  wire              SRST,
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [ADDR_W-1:0] PADDR,
  input  wire [31:0]       PWDATA,
  input  wire [3:0]        PSTRB,
  output reg  [31:0]       PRDATA,
  output reg               PREADY,
  output reg               PSLVERR,
  input  wire              DIV_TICK32,
  input  wire              DIV_TICK8,
  input  wire              DIV_TICK4,
  input  wire              DIV_TICK1,
  input  wire [6:0]        SEC_COUNT,
  input  wire [6:0]        MIN_COUNT,
  input  wire [5:0]        HOUR_COUNT,
  input  wire              HOUR_PM,
  input  wire              MODE_12H,
  input  wire              MODE_BCD,
  output reg               IRQ_REQ
);

  // ******************************************************************
  // Local states and declarations
  // ******************************************************************
  localparam ST_IDLE   = 1'b0;
  localparam ST_ANSWER = 1'b1;
  localparam N         = `TCI_CAUSES;

  reg  [N-1:0] irq_en;
  reg  [N-1:0] irq_flag;
  reg  [N-1:0] next_en;
  reg  [N-1:0] next_flag;
  reg          state;
  reg          next_state;
  reg  [3:0]   tick_meta;
  reg  [3:0]   tick_sync;
  reg  [3:0]   tick_prev;
  wire [3:0]   tick_raw;
  wire [3:0]   tick_rise;
  wire [5:0]   roll;
  wire [N-1:0] cause;
  wire [N-1:0] clear_mask;
  wire         access;
  wire         sel_en;
  wire         sel_flag;
  wire         do_write;
  wire [15:0]  wr_half;
  reg  [31:0]  rd_word;
  wire [N-1:0] en_word;
  wire [N-1:0] flag_word;
  wire [N-1:0] next_pend;

  // Named fields of the enable register
  wire day_irq_en     = irq_en[`TCI_BIT_DAY];
  wire halfday_irq_en = irq_en[`TCI_BIT_HALFDAY];
  wire hour_irq_en    = irq_en[`TCI_BIT_HOUR];
  wire tenmin_irq_en  = irq_en[`TCI_BIT_TENMIN];
  wire minute_irq_en  = irq_en[`TCI_BIT_MINUTE];
  wire tensec_irq_en  = irq_en[`TCI_BIT_TENSEC];
  wire tick1_irq_en   = irq_en[`TCI_BIT_T1];
  wire tick4_irq_en   = irq_en[`TCI_BIT_T4];
  wire tick8_irq_en   = irq_en[`TCI_BIT_T8];
  wire tick32_irq_en  = irq_en[`TCI_BIT_T32];

  // Named fields of the flag register
  wire day_flag     = irq_flag[`TCI_BIT_DAY];
  wire halfday_flag = irq_flag[`TCI_BIT_HALFDAY];
  wire hour_flag    = irq_flag[`TCI_BIT_HOUR];
  wire tenmin_flag  = irq_flag[`TCI_BIT_TENMIN];
  wire minute_flag  = irq_flag[`TCI_BIT_MINUTE];
  wire tensec_flag  = irq_flag[`TCI_BIT_TENSEC];
  wire tick1_flag   = irq_flag[`TCI_BIT_T1];
  wire tick4_flag   = irq_flag[`TCI_BIT_T4];
  wire tick8_flag   = irq_flag[`TCI_BIT_T8];
  wire tick32_flag  = irq_flag[`TCI_BIT_T32];

  // read-back order, day at bit 9 down to 32 Hz at bit 0
  assign en_word = {day_irq_en,
                    halfday_irq_en,
                    hour_irq_en,
                    tenmin_irq_en,
                    minute_irq_en,
                    tensec_irq_en,
                    tick1_irq_en,
                    tick4_irq_en,
                    tick8_irq_en,
                    tick32_irq_en};

  // flag read-back in the same order
  assign flag_word = {day_flag,
                      halfday_flag,
                      hour_flag,
                      tenmin_flag,
                      minute_flag,
                      tensec_flag,
                      tick1_flag,
                      tick4_flag,
                      tick8_flag,
                      tick32_flag};

  // Register index hit, used by both register selects
  function hit;
    input [ADDR_W-1:0] addr;
    input [15:0]       idx;
    begin
      hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    end
  endfunction

  // ******************************************************************
  // Divider tick capture
  // ******************************************************************
  assign tick_raw = {DIV_TICK1, DIV_TICK4, DIV_TICK8, DIV_TICK32};

  // Ticks come from the oscillator domain; one rising edge per period
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tick
      always @(posedge CORE_CLK) begin
        if (SRST) begin
          tick_meta[g] <= 1'b0;
          tick_sync[g] <= 1'b0;
          tick_prev[g] <= 1'b0;
        end else begin
          tick_meta[g] <= tick_raw[g];
          tick_sync[g] <= tick_meta[g];
          tick_prev[g] <= tick_sync[g];
        end
      end
      assign tick_rise[g] = tick_sync[g] & ~tick_prev[g];
    end
  endgenerate

  // ******************************************************************
  // Counter rollover capture
  // ******************************************************************
  tci_roll_detect u_roll (
    .clk        (CORE_CLK),
    .srst       (SRST),
    .sec_count  (SEC_COUNT),
    .min_count  (MIN_COUNT),
    .hour_count (HOUR_COUNT),
    .hour_pm    (HOUR_PM),
    .mode_12h   (MODE_12H),
    .mode_bcd   (MODE_BCD),
    .roll       (roll)
  );

  assign cause[`TCI_BIT_T32]     = tick_rise[0];
  assign cause[`TCI_BIT_T8]      = tick_rise[1];
  assign cause[`TCI_BIT_T4]      = tick_rise[2];
  assign cause[`TCI_BIT_T1]      = tick_rise[3];
  assign cause[`TCI_BIT_TENSEC]  = roll[0];
  assign cause[`TCI_BIT_MINUTE]  = roll[1];
  assign cause[`TCI_BIT_TENMIN]  = roll[2];
  assign cause[`TCI_BIT_HOUR]    = roll[3];
  assign cause[`TCI_BIT_HALFDAY] = roll[4];
  assign cause[`TCI_BIT_DAY]     = roll[5];

  // ******************************************************************
  // APB decode
  // ******************************************************************
  assign access   = PSEL & PENABLE;
  assign sel_en   = hit(PADDR, `TCI_IEN_IDX);
  assign sel_flag = hit(PADDR, `TCI_IFLG_IDX);
  // Write lands on the edge that completes the transfer
  assign do_write = access & PREADY & PWRITE & (state == ST_ANSWER);

  // Byte lanes 0 and 1 carry the 16-bit register
  assign wr_half = {PSTRB[1] ? PWDATA[15:8] : 8'h00, PSTRB[0] ? PWDATA[7:0] : 8'h00};

  always @* begin
    rd_word = 32'h00000000;
    if (sel_en) begin
      rd_word = {22'h000000, en_word};
    end else if (sel_flag) begin
      rd_word = {22'h000000, flag_word};
    end
  end

  assign clear_mask = (do_write && sel_flag) ? wr_half[N-1:0] : {N{1'b0}};

  // ******************************************************************
  // Next state of the registers
  // ******************************************************************
  always @* begin
    next_en = irq_en;
    if (do_write && sel_en) begin
      if (PSTRB[0]) begin
        next_en[7:0] = PWDATA[7:0];
      end
      if (PSTRB[1]) begin
        next_en[N-1:8] = PWDATA[N-1:8];
      end
    end
    // flag shows occurrence; a set in the clear cycle wins
    // Flags record every cause; the enable gates only the request
    next_flag = (irq_flag & ~clear_mask) | cause;
  end

  // each enable gates only its own flag
  assign next_pend = next_flag & next_en;

  // ******************************************************************
  // APB answer sequencing
  // ******************************************************************
  // One wait state: the answer is registered, so outputs stay flops
  always @* begin
    case (state)
      ST_IDLE: begin
        if (access) begin
          next_state = ST_ANSWER;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_ANSWER: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge CORE_CLK) begin
    if (SRST) begin
      state   <= ST_IDLE;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      state <= next_state;
      if ((state == ST_IDLE) && access) begin
        PREADY  <= 1'b1;
        PSLVERR <= ~(sel_en | sel_flag);
        PRDATA  <= PWRITE ? 32'h00000000 : rd_word;
      end else begin
        PREADY  <= 1'b0;
        PSLVERR <= 1'b0;
        PRDATA  <= 32'h00000000;
      end
    end
  end

  // ******************************************************************
  // Enable and flag registers
  // ******************************************************************
  // No clock gating here, so sleep leaves the request path alive
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      irq_en   <= `TCI_IEN_RST;
      irq_flag <= `TCI_IFLG_RST;
    end else begin
      irq_en   <= next_en;
      irq_flag <= next_flag;
    end
  end

  // ******************************************************************
  // Request to the interrupt controller
  // ******************************************************************
  // Taken from the next values so the request rises with its flag
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      IRQ_REQ <= 1'b0;
    end else begin
      IRQ_REQ <= |next_pend;
    end
  end

endmodule // tci_irq

//--- test/tci_irq_checker.sv
/*
 * Port-level checker for the timekeeper interrupt block.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "tci_consts.vh"

module tci_irq_checker #(
  parameter ADDR_W = 18
) (
  input wire logic              CORE_CLK,
  input wire logic              SRST,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [3:0]        PSTRB,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              IRQ_REQ
);
  wire mapped = (PADDR == {`TCI_IEN_IDX, 2'b00}) || (PADDR == {`TCI_IFLG_IDX, 2'b00});

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);

  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_ien_off;
    PREADY && PWRITE && mapped && PADDR[3] && PSTRB[1:0] == 2'b11 && PWDATA[9:0] == 10'h000;
  endsequence

  AST_READY_ONE: assert property (s_access |=> PREADY)
    else $error("ready not one cycle after access");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_UNMAPPED: assert property (PREADY && !mapped |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  AST_RSVD_ZERO: assert property (PREADY && mapped |-> !PSLVERR && PRDATA[31:10] == 22'h0)
    else $error("reserved bits not zero");
  AST_DATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside ready");
  AST_IRQ_HOLD: assert property (IRQ_REQ && !(PREADY && PWRITE) |=> IRQ_REQ)
    else $error("request dropped without a write");
  AST_DISABLE_QUIET: assert property (s_ien_off |=> !IRQ_REQ [*3])
    else $error("request with all enables off");
  AST_RST_QUIET: assert property ($fell(SRST) |-> !IRQ_REQ && !PREADY)
    else $error("outputs active after reset");
endmodule // tci_irq_checker

bind tci_irq tci_irq_checker #(.ADDR_W(ADDR_W)) u_tci_irq_checker (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .IRQ_REQ(IRQ_REQ)
);

//--- test/tci_far_model.sv
/*
 * Far-side model: divider ticks and calendar counters feeding the block.
 * Assumes its tasks are called right after a rising clock edge.
 */
`timescale 1ns/1ps

module tci_far_model (
  input  wire       clk,
  output wire       tick32,
  output wire       tick8,
  output wire       tick4,
  output wire       tick1,
  output reg  [6:0] sec_count = 7'h00,
  output reg  [6:0] min_count = 7'h00,
  output reg  [5:0] hour_count = 6'h00,
  output reg        hour_pm = 1'b0,
  output reg        mode_12h = 1'b0,
  output reg        mode_bcd = 1'b0
);
  reg [3:0] tk = 4'h0;
  assign {tick1, tick4, tick8, tick32} = tk;

  task tick(input integer i);
    begin
      tk[i] <= 1'b1;
      repeat (4) @(posedge clk);
      tk[i] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task set_cnt(input [6:0] s, input [6:0] m, input [5:0] h, input pm, input m12, input b);
    begin
      sec_count <= s;
      min_count <= m;
      hour_count <= h;
      hour_pm <= pm;
      mode_12h <= m12;
      mode_bcd <= b;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // tci_far_model

//--- test/tb_tci_irq.sv
/*
 * Self-checking bench for the timekeeper interrupt block over APB.
 * Assumes one wait state per transfer and the far-side model for causes.
 */
`timescale 1ns/1ps
`include "tci_consts.vh"

module tb_tci_irq;
  localparam [17:0] A_IEN = {`TCI_IEN_IDX, 2'b00};
  localparam [17:0] A_FLG = {`TCI_IFLG_IDX, 2'b00};
  reg         clk, srst, psel, penable, pwrite, er;
  reg  [17:0] paddr;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, irq_req, t32, t8, t4, t1, pm, m12, bcd;
  wire [6:0]  sec, mn;
  wire [5:0]  hr;
  integer     miscompares, n_tests, k;

  tci_irq #(.ADDR_W(18)) u_tci_irq (
    .CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DIV_TICK32(t32), .DIV_TICK8(t8), .DIV_TICK4(t4), .DIV_TICK1(t1),
    .SEC_COUNT(sec), .MIN_COUNT(mn), .HOUR_COUNT(hr), .HOUR_PM(pm), .MODE_12H(m12),
    .MODE_BCD(bcd), .IRQ_REQ(irq_req));
  tci_far_model u_tci_far_model (
    .clk(clk), .tick32(t32), .tick8(t8), .tick4(t4), .tick1(t1), .sec_count(sec),
    .min_count(mn), .hour_count(hr), .hour_pm(pm), .mode_12h(m12), .mode_bcd(bcd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t value mismatch got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // Holds the request until ready is sampled high
  task apb(input w, input [17:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 40) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= 40) begin
        chk(32'h0, 32'h1);
        results;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so a following call never reassigns psel in this step
      @(posedge clk);
    end
  endtask

  task rdchk(input [17:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask

  task irqchk(input e);
    begin
      @(posedge clk);
      chk({31'h0, irq_req}, {31'h0, e});
    end
  endtask

  // Old counters, flags cleared, then new counters and expected flags
  task roll(input [6:0] os, om, input [5:0] oh, input opm, input [6:0] ns, nm,
            input [5:0] nh, input npm, m, b, input [9:0] e);
    begin
      u_tci_far_model.set_cnt(os, om, oh, opm, m, b);
      apb(1'b1, A_FLG, 32'h3FF);
      u_tci_far_model.set_cnt(ns, nm, nh, npm, m, b);
      rdchk(A_FLG, {22'h0, e});
    end
  endtask

  task results;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    $display("[ERR] %0t watchdog expired", $time);
    miscompares = miscompares + 1;
    results;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata, rd, er} = {1'b1, 86'h0};
    miscompares = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdchk(A_IEN, 32'h0);
    rdchk(A_FLG, 32'h0);
    $display("Test 1 reset values done");
    apb(1'b1, A_IEN, 32'hFFFF_FFFF);
    rdchk(A_IEN, 32'h3FF);
    apb(1'b0, 18'h00100, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, A_IEN, 32'h0);
    rdchk(A_IEN, 32'h0);
    $display("Test 2 register access done");
    for (k = 0; k < 4; k = k + 1) begin
      u_tci_far_model.tick(k);
      rdchk(A_FLG, 32'h1 << k);
      chk({31'h0, irq_req}, 32'h0);
      apb(1'b1, A_FLG, 32'h0);
      rdchk(A_FLG, 32'h1 << k);
      apb(1'b1, A_FLG, 32'h1 << k);
      rdchk(A_FLG, 32'h0);
      chk({31'h0, irq_req}, 32'h0);
    end
    $display("Test 3 divider ticks done");
    roll(7'd9, 7'd3, 6'd5, 0, 7'd10, 7'd3, 6'd5, 0, 0, 0, 10'h010);
    roll(7'd10, 7'd3, 6'd5, 0, 7'd11, 7'd3, 6'd5, 0, 0, 0, 10'h000);
    roll(7'd59, 7'd59, 6'd23, 0, 7'd0, 7'd0, 6'd0, 0, 0, 0, 10'h3F0);
    roll(7'd0, 7'd9, 6'd11, 0, 7'd0, 7'd10, 6'd12, 0, 0, 0, 10'h140);
    roll(7'd5, 7'd5, 6'd11, 0, 7'd5, 7'd5, 6'd12, 1, 1, 0, 10'h100);
    roll(7'd5, 7'd5, 6'd11, 1, 7'd5, 7'd5, 6'd12, 0, 1, 0, 10'h300);
    roll(7'h59, 7'h19, 6'h05, 0, 7'h00, 7'h20, 6'h05, 0, 0, 1, 10'h070);
    $display("Test 4 rollovers done");
    apb(1'b1, A_FLG, 32'h3FF);
    apb(1'b1, A_IEN, 32'h1);
    u_tci_far_model.tick(1);
    irqchk(1'b0);
    u_tci_far_model.tick(0);
    irqchk(1'b1);
    apb(1'b1, A_FLG, 32'h0);
    irqchk(1'b1);
    apb(1'b1, A_FLG, 32'h1);
    irqchk(1'b0);
    rdchk(A_FLG, 32'h2);
    $display("Test 5 request path done");
    apb(1'b1, A_IEN, 32'h2);
    irqchk(1'b1);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({31'h0, irq_req}, 32'h0);
    rdchk(A_IEN, 32'h0);
    rdchk(A_FLG, 32'h0);
    $display("Test 6 reset in mid-run done");
    results;
  end
endmodule // tb_tci_irq
